// [logic/tspm_top.sv]
// Test signal probe mux with AXI4-Lite register slave
`timescale 1ns/100ps
module tspm_top (
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // AXI4-Lite write
    input wire logic [3:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // AXI4-Lite read
    input wire logic [3:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // Probe sources
    input wire logic [31:0] digital_sources,
    input wire logic gpio_out,
    input wire logic gpio_oe,
    // Probe pin and analog switch
    output logic probe_output_pin_o,
    output logic probe_output_pin_oe,
    output logic analog_buffer_enable,
    output logic [4:0] analog_channel_select
);
    import tspm_pkg::*;

    // ================================================================
    // Register state
    tspm_ctrl_type ctrl_reg, ctrl_next;
    logic [4:0] chan_reg, chan_next;
    logic aw_got_reg, aw_got_next;
    logic w_got_reg, w_got_next;
    logic [3:0] awaddr_reg, awaddr_next;
    logic [7:0] wbyte_reg, wbyte_next;
    logic wstrb0_reg, wstrb0_next;
    logic bvalid_reg, bvalid_next;
    logic [1:0] bresp_reg, bresp_next;
    logic rvalid_reg, rvalid_next;
    logic [1:0] rresp_reg, rresp_next;
    logic [31:0] rdata_reg, rdata_next;
    logic pin_o_reg, pin_o_next;
    logic pin_oe_reg, pin_oe_next;
    logic abuf_reg, abuf_next;
    logic [4:0] achan_reg, achan_next;
    logic awready_reg, awready_next;
    logic wready_reg, wready_next;
    logic arready_reg, arready_next;
    tspm_route_type route;
    logic route_out;
    logic route_oe;

    function automatic logic addr_known(input logic [3:0] a);
        addr_known = (a == TSPM_CONTROL_OFFSET) || (a == TSPM_CHANNEL_OFFSET)
            || (a == TSPM_STATUS_OFFSET);
    endfunction : addr_known

    function automatic logic [7:0] ctrl_read(input tspm_ctrl_type c);
        ctrl_read = {c.analog_probe_enable, c.digital_probe_enable, 1'b0,
            c.digital_probe_select}; // R7
    endfunction : ctrl_read

    tspm_route u_route (
        .ctrl(ctrl_reg),
        .digital_sources(digital_sources),
        .gpio_out(gpio_out),
        .gpio_oe(gpio_oe),
        .route(route),
        .pin_out(route_out),
        .pin_oe(route_oe)
    );

    // ================================================================
    // Bus next state
    always_comb begin
        ctrl_next = ctrl_reg;
        chan_next = chan_reg;
        aw_got_next = aw_got_reg;
        w_got_next = w_got_reg;
        awaddr_next = awaddr_reg;
        wbyte_next = wbyte_reg;
        wstrb0_next = wstrb0_reg;
        bvalid_next = bvalid_reg;
        bresp_next = bresp_reg;
        rvalid_next = rvalid_reg;
        rresp_next = rresp_reg;
        rdata_next = rdata_reg;
        if (s_axi_awvalid && !aw_got_reg && !bvalid_reg) begin
            aw_got_next = 1'b1;
            awaddr_next = s_axi_awaddr;
        end
        if (s_axi_wvalid && !w_got_reg && !bvalid_reg) begin
            w_got_next = 1'b1;
            wbyte_next = s_axi_wdata[7:0];
            wstrb0_next = s_axi_wstrb[0];
        end
        if (aw_got_reg && w_got_reg) begin
            aw_got_next = 1'b0;
            w_got_next = 1'b0;
            bvalid_next = 1'b1;
            bresp_next = addr_known(awaddr_reg) ? TSPM_RESP_OKAY : TSPM_RESP_SLVERR;
            if (wstrb0_reg && awaddr_reg == TSPM_CONTROL_OFFSET) begin
                ctrl_next = tspm_ctrl_type'({wbyte_reg[7:6], wbyte_reg[4:0]}); // R7
            end
            if (wstrb0_reg && awaddr_reg == TSPM_CHANNEL_OFFSET) begin
                chan_next = wbyte_reg[4:0];
            end
        end
        if (bvalid_reg && s_axi_bready) begin
            bvalid_next = 1'b0;
        end
        if (s_axi_arvalid && !rvalid_reg) begin
            rvalid_next = 1'b1;
            rresp_next = addr_known(s_axi_araddr) ? TSPM_RESP_OKAY : TSPM_RESP_SLVERR;
            unique case (s_axi_araddr)
                TSPM_CONTROL_OFFSET: rdata_next = {24'h000000, ctrl_read(ctrl_reg)};
                TSPM_CHANNEL_OFFSET: rdata_next = {27'h0000000, chan_reg};
                TSPM_STATUS_OFFSET: rdata_next = {30'h00000000, route};
                default: rdata_next = 32'h00000000;
            endcase
        end else if (rvalid_reg && s_axi_rready) begin
            rvalid_next = 1'b0;
        end
        // Ready from the next state, so the pins stay flop outputs
        awready_next = !aw_got_next && !bvalid_next;
        wready_next = !w_got_next && !bvalid_next;
        arready_next = !rvalid_next;
    end

    // ================================================================
    // Pin next state, registered so the pin never glitches on decode
    always_comb begin
        pin_o_next = route_out; // R3 R4 R5 R6
        pin_oe_next = route_oe;
        abuf_next = (route == TSPM_ROUTE_ANALOG); // R1 R5
        achan_next = chan_reg; // R2
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ctrl_reg <= tspm_ctrl_type'({TSPM_CONTROL_RESET[7:6], TSPM_CONTROL_RESET[4:0]}); // R7
            chan_reg <= TSPM_CHANNEL_RESET;
            aw_got_reg <= 1'b0;
            w_got_reg <= 1'b0;
            awaddr_reg <= 4'h0;
            wbyte_reg <= 8'h00;
            wstrb0_reg <= 1'b0;
            bvalid_reg <= 1'b0;
            bresp_reg <= TSPM_RESP_OKAY;
            rvalid_reg <= 1'b0;
            rresp_reg <= TSPM_RESP_OKAY;
            rdata_reg <= 32'h00000000;
            pin_o_reg <= 1'b0;
            pin_oe_reg <= 1'b0;
            abuf_reg <= 1'b0;
            achan_reg <= TSPM_CHANNEL_RESET;
            awready_reg <= 1'b1;
            wready_reg <= 1'b1;
            arready_reg <= 1'b1;
        end else begin
            ctrl_reg <= ctrl_next;
            chan_reg <= chan_next;
            aw_got_reg <= aw_got_next;
            w_got_reg <= w_got_next;
            awaddr_reg <= awaddr_next;
            wbyte_reg <= wbyte_next;
            wstrb0_reg <= wstrb0_next;
            bvalid_reg <= bvalid_next;
            bresp_reg <= bresp_next;
            rvalid_reg <= rvalid_next;
            rresp_reg <= rresp_next;
            rdata_reg <= rdata_next;
            pin_o_reg <= pin_o_next;
            pin_oe_reg <= pin_oe_next;
            abuf_reg <= abuf_next;
            achan_reg <= achan_next;
            awready_reg <= awready_next;
            wready_reg <= wready_next;
            arready_reg <= arready_next;
        end
    end

    assign s_axi_awready = awready_reg;
    assign s_axi_wready = wready_reg;
    assign s_axi_bvalid = bvalid_reg;
    assign s_axi_bresp = bresp_reg;
    assign s_axi_arready = arready_reg;
    assign s_axi_rvalid = rvalid_reg;
    assign s_axi_rresp = rresp_reg;
    assign s_axi_rdata = rdata_reg;
    assign probe_output_pin_o = pin_o_reg;
    assign probe_output_pin_oe = pin_oe_reg;
    assign analog_buffer_enable = abuf_reg;
    assign analog_channel_select = achan_reg;

    // ================================================================
    // Checks
    sequence s_ana_only;
        ctrl_reg.analog_probe_enable && !ctrl_reg.digital_probe_enable;
    endsequence
    a_analog_path_on: assert property (@(posedge aclk) disable iff (!aresetn) // R1
        s_ana_only |=> analog_buffer_enable && !probe_output_pin_oe)
        else $error("analog path not routed");
    a_analog_chan_follow: assert property (@(posedge aclk) disable iff (!aresetn) // R2
        analog_buffer_enable |-> analog_channel_select == $past(chan_reg))
        else $error("analog channel mismatch");
    a_digital_path_on: assert property (@(posedge aclk) disable iff (!aresetn) // R3
        ctrl_reg.digital_probe_enable |=> probe_output_pin_oe)
        else $error("digital path not driven");
    a_digital_select_bit: assert property (@(posedge aclk) disable iff (!aresetn) // R4
        ctrl_reg.digital_probe_enable |=>
        probe_output_pin_o == $past(digital_sources[ctrl_reg.digital_probe_select]))
        else $error("wrong digital source");
    a_digital_wins_both: assert property (@(posedge aclk) disable iff (!aresetn) // R5
        ctrl_reg.analog_probe_enable && ctrl_reg.digital_probe_enable |=>
        !analog_buffer_enable)
        else $error("analog not suppressed");
    a_gpio_normal_use: assert property (@(posedge aclk) disable iff (!aresetn) // R6
        !ctrl_reg.analog_probe_enable && !ctrl_reg.digital_probe_enable |=>
        probe_output_pin_oe == $past(gpio_oe) && probe_output_pin_o == $past(gpio_out))
        else $error("gpio function lost");
    a_bit5_reads_zero: assert property (@(posedge aclk) disable iff (!aresetn) // R7
        s_axi_arvalid && !rvalid_reg && s_axi_araddr == TSPM_CONTROL_OFFSET |=>
        s_axi_rdata[5] == 1'b0 && s_axi_rvalid)
        else $error("reserved bit read nonzero");
    a_reset_clears_ctrl: assert property (@(posedge aclk) // R7
        !aresetn |=> ctrl_read(ctrl_reg) == TSPM_CONTROL_RESET)
        else $error("control not reset");
endmodule : tspm_top

// [logic/tspm_pkg.sv]
// Package of constants and types for the test signal probe mux
// ====================================================================
// Contract
// R1: Setting the analog probe enable bit 7 routes the analog mux output through the buffer to the probe pin.
// R2: While the analog path is on, the converter channel-select field picks the analog signal.
// R3: Setting the digital probe enable bit 6 routes the digital mux output to the probe pin.
// R4: The digital probe select field in bits 4 to 0 picks the digital signal, e.g. 00111 overcurrent, 10011 PWM.
// R5: With both enables set only the digital mux output reaches the probe pin.
// R6: With both enables clear the probe pin keeps its normal general-purpose function.
// R7: All writable control bits reset to zero and bit 5 always reads zero with writes ignored.
package tspm_pkg;
    // ================================================================
    // Register map
    localparam logic [3:0] TSPM_CONTROL_OFFSET = 4'h0;
    localparam logic [3:0] TSPM_CHANNEL_OFFSET = 4'h4;
    localparam logic [3:0] TSPM_STATUS_OFFSET = 4'h8;
    localparam int TSPM_ANALOG_EN_BIT = 7;
    localparam int TSPM_DIGITAL_EN_BIT = 6;
    localparam logic [7:0] TSPM_CONTROL_WMASK = 8'hDF;
    localparam logic [7:0] TSPM_CONTROL_RESET = 8'h00;
    localparam logic [4:0] TSPM_CHANNEL_RESET = 5'h00;
    localparam logic [4:0] TSPM_SEL_OVERCURRENT = 5'h07;
    localparam logic [4:0] TSPM_SEL_PWM_OUT = 5'h13;
    localparam logic [1:0] TSPM_RESP_OKAY = 2'h0;
    localparam logic [1:0] TSPM_RESP_SLVERR = 2'h2;
    // ================================================================
    // Probe route selection
    typedef enum logic [1:0] {
        TSPM_ROUTE_GPIO = 2'b00,
        TSPM_ROUTE_ANALOG = 2'b01,
        TSPM_ROUTE_DIGITAL = 2'b10
    } tspm_route_type;
    typedef struct packed {
        logic analog_probe_enable;
        logic digital_probe_enable;
        logic [4:0] digital_probe_select;
    } tspm_ctrl_type;
endpackage : tspm_pkg

// [logic/tspm_route.sv]
// Route decision and digital source selection for the probe pin
`timescale 1ns/100ps
module tspm_route (
    // Control
    input wire tspm_pkg::tspm_ctrl_type ctrl,
    // Signal sources
    input wire logic [31:0] digital_sources,
    input wire logic gpio_out,
    input wire logic gpio_oe,
    // Result
    output tspm_pkg::tspm_route_type route,
    output logic pin_out,
    output logic pin_oe
);
    import tspm_pkg::*;
    always_comb begin
        if (ctrl.digital_probe_enable) begin
            route = TSPM_ROUTE_DIGITAL; // R3 R5
            pin_out = digital_sources[ctrl.digital_probe_select]; // R4
            pin_oe = 1'b1;
        end else if (ctrl.analog_probe_enable) begin
            route = TSPM_ROUTE_ANALOG; // R1
            pin_out = 1'b0;
            pin_oe = 1'b0;
        end else begin
            route = TSPM_ROUTE_GPIO; // R6
            pin_out = gpio_out;
            pin_oe = gpio_oe;
        end
    end
endmodule : tspm_route

// [tb/tspm_probe_meter.sv]
// Bench instrument model that measures the probe pin
`timescale 1ns/100ps
module tspm_probe_meter #(
    parameter logic PULL_LEVEL = 1'b1
) (
    // Pin side
    input wire logic pin_o,
    input wire logic pin_oe,
    input wire logic buffer_on,
    // Readings
    output logic level,
    output logic analog_seen
);
    // ================================================================
    // Measurement
    // Released pin goes to the board pull level, never the stale value
    assign level = pin_oe ? pin_o : PULL_LEVEL;
    assign analog_seen = buffer_on;
endmodule : tspm_probe_meter

// [tb/test_test_signal_probe_mux.sv]
// Register and probe routing tests for the test signal probe mux
`timescale 1ns/100ps
module test_test_signal_probe_mux;
    import tspm_pkg::*;
    // ================================================================
    // Stimulus and observed signals
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    logic [3:0] awaddr = 4'h0, araddr = 4'h0, wstrb = 4'hF;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic [31:0] wdata = 32'h0, srcs = 32'h0, rdata;
    logic gout = 1'b0, goe = 1'b0;
    logic awready, wready, bvalid, arready, rvalid, pin_o, pin_oe, buf_en, level, an_seen;
    logic [1:0] bresp, rresp;
    logic [4:0] ch;
    logic [4:0] codes [2] = '{TSPM_SEL_OVERCURRENT, TSPM_SEL_PWM_OUT};
    int n_errors = 0;
    int n_checks = 0;
    tspm_top DUT (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
        .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
        .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
        .s_axi_rready(rready), .digital_sources(srcs), .gpio_out(gout), .gpio_oe(goe),
        .probe_output_pin_o(pin_o), .probe_output_pin_oe(pin_oe),
        .analog_buffer_enable(buf_en), .analog_channel_select(ch));
    tspm_probe_meter meter (.pin_o(pin_o), .pin_oe(pin_oe), .buffer_on(buf_en),
        .level(level), .analog_seen(an_seen));
    initial begin
        forever #50 aclk = ~aclk;
    end
    // ================================================================
    // Tasks
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : check
    // Handshakes are judged at the falling edge, where ready is settled
    task automatic axi_write(input logic [3:0] a, input logic [31:0] d, input logic [1:0] er);
        logic aw_ok, w_ok, b_ok;
        logic [1:0] resp;
        @(posedge aclk);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        b_ok = 1'b0;
        while (!b_ok) begin
            @(negedge aclk);
            aw_ok = awvalid && awready === 1'b1;
            w_ok = wvalid && wready === 1'b1;
            b_ok = bvalid === 1'b1;
            resp = bresp;
            @(posedge aclk);
            if (aw_ok) awvalid <= 1'b0;
            if (w_ok) wvalid <= 1'b0;
        end
        bready <= 1'b0;
        check(32'(resp), 32'(er));
    endtask : axi_write
    task automatic axi_read(input logic [3:0] a, input logic [31:0] ed, input logic [1:0] er);
        logic ar_ok, r_ok;
        logic [31:0] d;
        logic [1:0] resp;
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        r_ok = 1'b0;
        while (!r_ok) begin
            @(negedge aclk);
            ar_ok = arvalid && arready === 1'b1;
            r_ok = rvalid === 1'b1;
            d = rdata;
            resp = rresp;
            @(posedge aclk);
            if (ar_ok) arvalid <= 1'b0;
        end
        rready <= 1'b0;
        check(d, ed);
        check(32'(resp), 32'(er));
    endtask : axi_read
    // Register update plus one cycle of pin latency, with margin
    task automatic settle;
        repeat (3) @(posedge aclk);
        @(negedge aclk);
    endtask : settle
    task automatic results;
        $display("checks %0d errors %0d", n_checks, n_errors);
        if (n_errors == 0 && n_checks > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask : results
    // ================================================================
    // Tests
    initial begin
        repeat (8) @(posedge aclk);
        aresetn <= 1'b1;
        axi_read(TSPM_CONTROL_OFFSET, 32'(TSPM_CONTROL_RESET), TSPM_RESP_OKAY);
        axi_read(TSPM_CHANNEL_OFFSET, 32'(TSPM_CHANNEL_RESET), TSPM_RESP_OKAY);
        axi_write(TSPM_CONTROL_OFFSET, 32'hFF, TSPM_RESP_OKAY);
        axi_read(TSPM_CONTROL_OFFSET, 32'(TSPM_CONTROL_WMASK), TSPM_RESP_OKAY);
        for (int i = 0; i < 2; i++) begin
            axi_write(TSPM_CONTROL_OFFSET, 32'h40 | 32'(codes[i]), TSPM_RESP_OKAY);
            srcs <= 32'h1 << codes[i];
            settle();
            check(32'(level), 32'h1);
            check(32'(pin_oe), 32'h1);
            srcs <= ~(32'h1 << codes[i]);
            settle();
            check(32'(level), 32'h0);
        end
        // Both enables set: the digital path must win
        axi_write(TSPM_CONTROL_OFFSET, 32'hC7, TSPM_RESP_OKAY);
        srcs <= 32'h80;
        settle();
        check(32'(level), 32'h1);
        check(32'(an_seen), 32'h0);
        axi_read(TSPM_STATUS_OFFSET, 32'(TSPM_ROUTE_DIGITAL), TSPM_RESP_OKAY);
        axi_write(TSPM_CHANNEL_OFFSET, 32'h0B, TSPM_RESP_OKAY);
        axi_write(TSPM_CONTROL_OFFSET, 32'h80, TSPM_RESP_OKAY);
        settle();
        check(32'(an_seen), 32'h1);
        check(32'(pin_oe), 32'h0);
        check(32'(ch), 32'h0B);
        axi_read(TSPM_STATUS_OFFSET, 32'(TSPM_ROUTE_ANALOG), TSPM_RESP_OKAY);
        axi_write(TSPM_CONTROL_OFFSET, 32'h00, TSPM_RESP_OKAY);
        gout <= 1'b1;
        goe <= 1'b1;
        settle();
        check({pin_oe, pin_o, an_seen}, 32'h6);
        gout <= 1'b0;
        goe <= 1'b0;
        settle();
        check({pin_oe, an_seen}, 32'h0);
        axi_read(TSPM_STATUS_OFFSET, 32'(TSPM_ROUTE_GPIO), TSPM_RESP_OKAY);
        // Unmapped offset and cleared byte strobe change nothing
        axi_write(4'hC, 32'hFF, TSPM_RESP_SLVERR);
        axi_read(4'hC, 32'h0, TSPM_RESP_SLVERR);
        axi_read(TSPM_CONTROL_OFFSET, 32'h00, TSPM_RESP_OKAY);
        wstrb <= 4'hE;
        axi_write(TSPM_CONTROL_OFFSET, 32'hFF, TSPM_RESP_OKAY);
        axi_read(TSPM_CONTROL_OFFSET, 32'h00, TSPM_RESP_OKAY);
        results();
    end
    // Tests need well under a thousand cycles
    initial begin
        repeat (5000) @(posedge aclk);
        n_errors++;
        results();
    end
endmodule : test_test_signal_probe_mux
